// ---- hdl/main_memory_select_decode.sv ----
// Contract
// - hole bottom compares against pci ad[23:16]
// - hole top compares against pci ad[23:16]
// - no select inside hole, bounds inclusive
// - top below bottom disables the hole
// - hole matches only when ad[31:24] zero
// - hole bottom resets 10h, top 0fh
// - top of memory maps to ad[28:21]
// - select from 2 mbytes to top, minus hole
// - zero top of memory disables region
// - all ones top reaches 512 mbytes minus one
// - isa control governs forwarding to pci
// - upper nibble sets isa top, 1-mbyte steps
// - isa cycles in 1-mbyte-to-top region forward
// - top of memory resets 00h, isa control 01h
// - master enable clear never asserts select
// - low four bits enable legacy block forwarding, bit 3 only while bios_cs_enable is low
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module main_memory_select_decode #(
	parameter int pci_addr_width = 32, // pci address bus
	parameter int isa_addr_width = 24, // isa / dma memory address
	parameter int count_width = 8 // width of the event counters
) (
	input wire logic mclk,
	input wire logic reset,
	// configuration port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// neighbouring control register bits, same clock
	input wire logic select_master_enable,
	input wire logic bios_cs_enable,
	// pci memory decode request
	input wire logic pci_mem_valid,
	input wire logic [pci_addr_width-1:0] pci_addr,
	output logic main_memory_select_n,
	output logic pci_decode_done,
	// isa / dma memory decode request
	input wire logic isa_mem_valid,
	input wire logic [isa_addr_width-1:0] isa_addr,
	output logic isa_forward_pci,
	output logic isa_decode_done
);

	// configuration registers
	logic [7:0] hole_bottom_q; // lower hole bound, ad[23:16]
	logic [7:0] hole_top_q; // upper hole bound, ad[23:16]
	logic [7:0] main_memory_top_q; // top of memory, ad[28:21]
	logic [7:0] isa_forward_decode_control_q; // isa top nibble and block enables

	// observable decode state
	logic main_memory_select_n_q; // registered select, active low
	logic pci_decode_done_q; // one-cycle pulse per pci decode
	logic isa_forward_pci_q; // registered forward decision
	logic isa_decode_done_q; // one-cycle pulse per isa decode
	logic last_in_hole_q; // last pci decode fell in the hole
	logic [count_width-1:0] select_count_q; // saturating count of selects
	logic [count_width-1:0] forward_count_q; // saturating count of forwards
	logic [7:0] reg_rdata_q; // read data, valid the cycle after reg_rd

	// write strobes, one per register
	logic wr_hole_bottom;
	logic wr_hole_top;
	logic wr_main_memory_top;
	logic wr_isa_control;
	logic wr_select_count;
	logic wr_forward_count;

	// address decode of the write port; reads are decoded in the mux below
	assign wr_hole_bottom = reg_wr && (reg_addr == memsel_pkg::off_hole_bottom);
	assign wr_hole_top = reg_wr && (reg_addr == memsel_pkg::off_hole_top);
	assign wr_main_memory_top = reg_wr && (reg_addr == memsel_pkg::off_main_memory_top);
	assign wr_isa_control = reg_wr
		&& (reg_addr == memsel_pkg::off_isa_forward_decode_control);
	assign wr_select_count = reg_wr && (reg_addr == memsel_pkg::off_select_count);
	assign wr_forward_count = reg_wr && (reg_addr == memsel_pkg::off_forward_count);

	// hole bottom register
	always_ff @(posedge mclk) begin
		if (reset) begin
			hole_bottom_q <= memsel_pkg::rst_hole_bottom;
		end else if (wr_hole_bottom) begin
			// no range check: keeping it at or above 1 mbyte is software's job
			hole_bottom_q <= reg_wdata;
		end
	end

	// hole top register
	always_ff @(posedge mclk) begin
		if (reset) begin
			// top one below bottom, so the hole starts out disabled
			hole_top_q <= memsel_pkg::rst_hole_top;
		end else if (wr_hole_top) begin
			hole_top_q <= reg_wdata;
		end
	end

	// top of main memory register
	always_ff @(posedge mclk) begin
		if (reset) begin
			main_memory_top_q <= memsel_pkg::rst_main_memory_top;
		end else if (wr_main_memory_top) begin
			main_memory_top_q <= reg_wdata;
		end
	end

	// isa address decoder control register
	always_ff @(posedge mclk) begin
		if (reset) begin
			// only the 0-512k block forwards after reset
			isa_forward_decode_control_q <= memsel_pkg::rst_isa_forward_decode_control;
		end else if (wr_isa_control) begin
			isa_forward_decode_control_q <= reg_wdata;
		end
	end

	// pci side: main memory select
	logic [7:0] pci_hole_field; // ad[23:16]
	logic [7:0] pci_tom_field; // ad[28:21]
	logic hole_in_range; // both bounds met
	logic hole_enabled; // top not below bottom
	logic hole_high_zero; // ad[31:24] all zero
	logic pci_in_hole; // address excluded by the hole
	logic tom_in_range; // 2 mbytes <= address <= top of memory
	logic tom_high_zero; // ad[31:29] all zero
	logic pci_region_hit; // inside the 2-mbyte-to-top region
	logic pci_select; // final select decision, active high

	assign pci_hole_field = pci_addr[memsel_pkg::hole_field_msb:memsel_pkg::hole_field_lsb];
	assign pci_tom_field = pci_addr[memsel_pkg::tom_field_msb:memsel_pkg::tom_field_lsb];

	// both hole bounds are inclusive on the 64-kbyte granule
	range_compare #(
		.width(8)
	) hole_compare (
		.value(pci_hole_field),
		.lo(hole_bottom_q),
		.hi(hole_top_q),
		.in_range(hole_in_range)
	);

	// top below bottom means no address can be excluded
	assign hole_enabled = (hole_top_q >= hole_bottom_q);

	// the hole never reaches above 16 mbytes
	assign hole_high_zero = (pci_addr[pci_addr_width-1:memsel_pkg::hole_zero_lsb] == '0);

	assign pci_in_hole = hole_enabled && hole_high_zero && hole_in_range;

	// region [2 mbytes, (top+1)*2 mbytes - 1]; top of zero leaves it empty,
	// and ff reaches 512 mbytes - 1 because ad[31:29] must be zero
	range_compare #(
		.width(8)
	) tom_compare (
		.value(pci_tom_field),
		.lo(memsel_pkg::tom_floor),
		.hi(main_memory_top_q),
		.in_range(tom_in_range)
	);

	assign tom_high_zero = (pci_addr[pci_addr_width-1:memsel_pkg::tom_zero_lsb] == '0);
	assign pci_region_hit = tom_in_range && tom_high_zero;

	// master enable gates everything, then the hole carves out its piece
	assign pci_select = select_master_enable && pci_region_hit && !pci_in_hole;

	// registered select; released high whenever no decode is presented
	always_ff @(posedge mclk) begin
		if (reset) begin
			main_memory_select_n_q <= 1'b1;
		end else begin
			main_memory_select_n_q <= !(pci_mem_valid && pci_select);
		end
	end

	// decode completion pulse, aligned with the select output
	always_ff @(posedge mclk) begin
		if (reset) begin
			pci_decode_done_q <= 1'b0;
		end else begin
			pci_decode_done_q <= pci_mem_valid;
		end
	end

	// remembers whether the last pci decode was excluded by the hole
	always_ff @(posedge mclk) begin
		if (reset) begin
			last_in_hole_q <= 1'b0;
		end else if (pci_mem_valid) begin
			last_in_hole_q <= pci_in_hole;
		end
	end

	// isa side: forwarding of isa master and dma memory cycles to pci
	logic [3:0] isa_top_nibble; // control bits 7:4
	logic [3:0] isa_mb_field; // isa address bits 23:20
	logic [3:0] isa_64k_field; // isa address bits 19:16
	logic isa_region_hit; // 1 mbyte <= address < (n+1) mbytes
	logic isa_below_1mb; // address under 1 mbyte
	logic [memsel_pkg::legacy_blocks-1:0] legacy_hit; // address inside block i
	logic [memsel_pkg::legacy_blocks-1:0] legacy_enable; // forwarding enables
	logic legacy_forward; // any enabled legacy block matched
	logic isa_forward; // final forward decision

	assign isa_top_nibble = isa_forward_decode_control_q[memsel_pkg::isa_top_msb:
		memsel_pkg::isa_top_lsb];
	assign isa_mb_field = isa_addr[memsel_pkg::isa_mb_msb:memsel_pkg::isa_mb_lsb];
	assign isa_64k_field = isa_addr[memsel_pkg::isa_64k_msb:memsel_pkg::isa_64k_lsb];

	// nibble n gives boundary (n+1) mbytes, so mbyte numbers 1..n forward;
	// a nibble of zero therefore leaves the region empty
	range_compare #(
		.width(4)
	) isa_top_compare (
		.value(isa_mb_field),
		.lo(memsel_pkg::isa_region_floor),
		.hi(isa_top_nibble),
		.in_range(isa_region_hit)
	);

	assign isa_below_1mb = (isa_mb_field == 4'h0);

	// the bios chip select keeps the low bios block on isa when it is on
	always_comb begin
		legacy_enable = isa_forward_decode_control_q[memsel_pkg::legacy_blocks-1:0];
		if (bios_cs_enable) begin
			legacy_enable[memsel_pkg::bios_block] = 1'b0;
		end
	end

	// one comparator per legacy block, on the 64-kbyte unit
	genvar blk;
	generate
		for (blk = 0; blk < memsel_pkg::legacy_blocks; blk++) begin : g_legacy
			logic block_inside; // 64-kbyte unit lies in this block
			range_compare #(
				.width(4)
			) block_compare (
				.value(isa_64k_field),
				.lo(memsel_pkg::legacy_lo[blk*4 +: 4]),
				.hi(memsel_pkg::legacy_hi[blk*4 +: 4]),
				.in_range(block_inside)
			);
			assign legacy_hit[blk] = isa_below_1mb && block_inside;
		end
	endgenerate

	assign legacy_forward = |(legacy_hit & legacy_enable);
	assign isa_forward = isa_region_hit || legacy_forward;

	// registered forward decision; low when no isa decode is presented
	always_ff @(posedge mclk) begin
		if (reset) begin
			isa_forward_pci_q <= 1'b0;
		end else begin
			isa_forward_pci_q <= isa_mem_valid && isa_forward;
		end
	end

	// isa decode completion pulse, aligned with the forward output
	always_ff @(posedge mclk) begin
		if (reset) begin
			isa_decode_done_q <= 1'b0;
		end else begin
			isa_decode_done_q <= isa_mem_valid;
		end
	end

	// event counters: saturate instead of wrapping so a busy system
	// never reads back a small misleading number; a write to its own offset clears a counter
	logic [count_width-1:0] select_count_d;
	logic [count_width-1:0] forward_count_d;

	// an event in the clearing cycle still counts: set wins over clear
	always_comb begin
		select_count_d = select_count_q;
		if (wr_select_count) begin
			select_count_d = '0;
		end
		if (pci_mem_valid && pci_select && (select_count_d != '1)) begin
			select_count_d = select_count_d + 1'b1;
		end
	end

	always_comb begin
		forward_count_d = forward_count_q;
		if (wr_forward_count) begin
			forward_count_d = '0;
		end
		if (isa_mem_valid && isa_forward && (forward_count_d != '1)) begin
			forward_count_d = forward_count_d + 1'b1;
		end
	end

	// counter registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			select_count_q <= '0;
			forward_count_q <= '0;
		end else begin
			select_count_q <= select_count_d;
			forward_count_q <= forward_count_d;
		end
	end

	// read back
	logic [7:0] status_word; // live view of the decoder state
	logic [7:0] read_mux; // selected read value

	always_comb begin
		status_word = 8'h00;
		status_word[memsel_pkg::st_hole_enabled] = hole_enabled;
		status_word[memsel_pkg::st_region_enabled] = (main_memory_top_q != 8'h00);
		status_word[memsel_pkg::st_master_enable] = select_master_enable;
		status_word[memsel_pkg::st_last_select] = !main_memory_select_n_q;
		status_word[memsel_pkg::st_last_forward] = isa_forward_pci_q;
		status_word[memsel_pkg::st_last_in_hole] = last_in_hole_q;
	end

	// unmapped offsets read as zero
	always_comb begin
		unique case (reg_addr)
			memsel_pkg::off_hole_bottom: read_mux = hole_bottom_q;
			memsel_pkg::off_hole_top: read_mux = hole_top_q;
			memsel_pkg::off_main_memory_top: read_mux = main_memory_top_q;
			memsel_pkg::off_isa_forward_decode_control: read_mux = isa_forward_decode_control_q;
			memsel_pkg::off_decode_status: read_mux = status_word;
			memsel_pkg::off_select_count: read_mux = 8'(select_count_q);
			memsel_pkg::off_forward_count: read_mux = 8'(forward_count_q);
			default: read_mux = 8'h00;
		endcase
	end

	// read data stands only in the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (reset) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_q <= read_mux;
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata = reg_rdata_q;
	assign main_memory_select_n = main_memory_select_n_q;
	assign pci_decode_done = pci_decode_done_q;
	assign isa_forward_pci = isa_forward_pci_q;
	assign isa_decode_done = isa_decode_done_q;

endmodule : main_memory_select_decode
`default_nettype wire

// ---- pkg/memsel_pkg.sv ----
`default_nettype none
package memsel_pkg;
	// register offsets on the configuration port
	localparam logic [7:0] off_hole_bottom = 8'h45;
	localparam logic [7:0] off_hole_top = 8'h46;
	localparam logic [7:0] off_main_memory_top = 8'h47;
	localparam logic [7:0] off_isa_forward_decode_control = 8'h48;
	localparam logic [7:0] off_decode_status = 8'h49;
	localparam logic [7:0] off_select_count = 8'h4a;
	localparam logic [7:0] off_forward_count = 8'h4b;

	// values after reset
	localparam logic [7:0] rst_hole_bottom = 8'h10;
	localparam logic [7:0] rst_hole_top = 8'h0f;
	localparam logic [7:0] rst_main_memory_top = 8'h00;
	localparam logic [7:0] rst_isa_forward_decode_control = 8'h01;
	localparam logic [7:0] rst_count = 8'h00;

	// pci address fields
	localparam int hole_field_lsb = 16; // hole bounds face ad[23:16]
	localparam int hole_field_msb = 23;
	localparam int hole_zero_lsb = 24; // ad[31:24] must be zero for the hole
	localparam int tom_field_lsb = 21; // top of memory faces ad[28:21]
	localparam int tom_field_msb = 28;
	localparam int tom_zero_lsb = 29; // above 512 mbytes never selects
	localparam logic [7:0] tom_floor = 8'h01; // 2 mbytes in 2-mbyte units

	// isa forward control fields
	localparam int isa_top_lsb = 4; // nibble 7:4, boundary in 1-mbyte steps
	localparam int isa_top_msb = 7;
	localparam int legacy_blocks = 4; // bits 3:0, one per legacy block
	localparam int isa_mb_lsb = 20; // isa address bits 23:20 = mbyte number
	localparam int isa_mb_msb = 23;
	localparam int isa_64k_lsb = 16; // 64-kbyte unit below 1 mbyte
	localparam int isa_64k_msb = 19;
	localparam logic [3:0] isa_region_floor = 4'h1; // region starts at 1 mbyte
	localparam int bios_block = 3; // block overridden by the bios chip select

	// legacy block bounds in 64-kbyte units, block i at [i*4 +: 4]
	// block 0: 0-512k, 1: 512-640k, 2: 640-768k vga, 3: 896-960k low bios
	localparam logic [15:0] legacy_lo = 16'he_a_8_0;
	localparam logic [15:0] legacy_hi = 16'he_b_9_7;

	// status register bit positions
	localparam int st_hole_enabled = 0;
	localparam int st_region_enabled = 1;
	localparam int st_master_enable = 2;
	localparam int st_last_select = 3;
	localparam int st_last_forward = 4;
	localparam int st_last_in_hole = 5;
endpackage : memsel_pkg
`default_nettype wire

// ---- hdl/range_compare.sv ----
`timescale 1ns/10ps
`default_nettype none
// inclusive range check: lo <= value <= hi, all unsigned
module range_compare #(
	parameter int width = 8
) (
	input wire logic [width-1:0] value,
	input wire logic [width-1:0] lo,
	input wire logic [width-1:0] hi,
	output logic in_range
);
	// purely combinational; an empty range (hi < lo) never matches
	assign in_range = (value >= lo) && (value <= hi);
endmodule : range_compare
`default_nettype wire

// ---- testbench/pci_master_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// far-side pci requester: presents one address per requested cycle
module pci_master_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic req, // bench asks for a cycle
	input wire logic [31:0] req_addr, // address to present
	output logic pci_mem_valid,
	output logic [31:0] pci_addr
);
	// launch one edge after the ask; back-to-back asks give back-to-back cycles
	always_ff @(posedge mclk) begin
		if (reset) begin
			pci_mem_valid <= 1'b0;
			pci_addr <= 32'h0000_0000;
		end else if (req) begin
			pci_mem_valid <= 1'b1;
			pci_addr <= req_addr;
		end else begin
			// released bus: invert so a stale address never looks held
			pci_mem_valid <= 1'b0;
			pci_addr <= ~pci_addr;
		end
	end
endmodule : pci_master_model
`default_nettype wire

// ---- testbench/main_memory_select_decode_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the decoder, one clock domain
module main_memory_select_decode_assertions #(
	parameter int pci_addr_width = 32,
	parameter int isa_addr_width = 24,
	parameter int count_width = 8
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic select_master_enable,
	input wire logic pci_mem_valid,
	input wire logic [pci_addr_width-1:0] pci_addr,
	input wire logic main_memory_select_n,
	input wire logic pci_decode_done,
	input wire logic isa_mem_valid,
	input wire logic [isa_addr_width-1:0] isa_addr,
	input wire logic isa_forward_pci,
	input wire logic isa_decode_done
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// done is the request delayed by exactly one cycle
	chk_pci_done_delay: assert property (1'b1 |=> pci_decode_done == $past(pci_mem_valid))
		else $error("pci done does not follow valid");
	// no request, no select
	chk_sel_needs_valid: assert property (!pci_mem_valid |=> main_memory_select_n)
		else $error("select without request");
	// master enable off blocks every select
	chk_master_off: assert property (!select_master_enable |=> main_memory_select_n)
		else $error("select while master disabled");
	// below 2 mbytes is never selected here
	chk_below_two_mb: assert property (pci_mem_valid && pci_addr[31:21] == 11'h000
		|=> main_memory_select_n)
		else $error("select below 2 mbytes");
	// at or above 512 mbytes is never selected
	chk_above_top: assert property (pci_mem_valid && pci_addr[31:29] != 3'h0
		|=> main_memory_select_n)
		else $error("select at or above 512 mbytes");
	// isa done tracks its request
	chk_isa_done_delay: assert property (isa_mem_valid |=> isa_decode_done)
		else $error("isa done missing");
	chk_isa_idle_quiet: assert property (!isa_mem_valid |=> !isa_decode_done && !isa_forward_pci)
		else $error("isa output without request");
	// gaps between the legacy blocks always stay on isa
	chk_isa_gap_local: assert property (isa_mem_valid && isa_addr[23:20] == 4'h0
		&& isa_addr[19:16] inside {4'hc, 4'hd, 4'hf} |=> !isa_forward_pci)
		else $error("forward in a non-block gap");
	// read data stands only after a read strobe
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");
	cov_select: cover property (pci_mem_valid ##1 !main_memory_select_n);
	cov_forward: cover property (isa_mem_valid ##1 isa_forward_pci);
	cov_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule : main_memory_select_decode_assertions
bind main_memory_select_decode main_memory_select_decode_assertions #(
	.pci_addr_width(pci_addr_width), .isa_addr_width(isa_addr_width),
	.count_width(count_width)) chk_inst (.mclk(mclk), .reset(reset), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .select_master_enable(select_master_enable),
	.pci_mem_valid(pci_mem_valid), .pci_addr(pci_addr),
	.main_memory_select_n(main_memory_select_n), .pci_decode_done(pci_decode_done),
	.isa_mem_valid(isa_mem_valid), .isa_addr(isa_addr), .isa_forward_pci(isa_forward_pci),
	.isa_decode_done(isa_decode_done));
`default_nettype wire

// ---- testbench/main_memory_select_decode_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module main_memory_select_decode_tb;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic master_en = 1'b0; // neighbour enable bit
	logic bios_en = 1'b0; // bios chip select keeps block 3 local
	logic req = 1'b0; // ask the pci model for a cycle
	logic [31:0] req_addr = 32'h0;
	logic pci_mem_valid;
	logic [31:0] pci_addr;
	logic sel_n, pci_done, isa_valid = 1'b0, fwd, isa_done;
	logic [23:0] isa_addr = 24'h0;
	int miscompares = 0;
	int checks_done = 0;
	// clock at 25 ns
	always #12.5 mclk = ~mclk;
	pci_master_model pci_master_model_inst (.mclk(mclk), .reset(reset), .req(req),
		.req_addr(req_addr), .pci_mem_valid(pci_mem_valid), .pci_addr(pci_addr));
	main_memory_select_decode main_memory_select_decode_inst (.mclk(mclk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .select_master_enable(master_en), .bios_cs_enable(bios_en),
		.pci_mem_valid(pci_mem_valid), .pci_addr(pci_addr), .main_memory_select_n(sel_n),
		.pci_decode_done(pci_done), .isa_mem_valid(isa_valid), .isa_addr(isa_addr),
		.isa_forward_pci(fwd), .isa_decode_done(isa_done));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test;
		if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	// expected select from the region and hole rules
	function automatic logic exp_hole(input logic [31:0] a, input logic [7:0] b, t);
		return t >= b && a[31:24] == 8'h00 && a[23:16] >= b && a[23:16] <= t;
	endfunction : exp_hole
	function automatic logic exp_sel(input logic [31:0] a, input logic [7:0] b, t, m,
		input logic en);
		return en && a[31:29] == 3'h0 && a[28:21] >= 8'h01 && a[28:21] <= m
			&& !exp_hole(a, b, t);
	endfunction : exp_sel
	// expected forward: 1-mbyte steps above, legacy blocks below 1 mbyte
	function automatic logic exp_fwd(input logic [23:0] a, input logic [7:0] c,
		input logic bios);
		logic [3:0] u;
		u = a[19:16];
		if (a[23:20] != 4'h0) return a[23:20] <= c[7:4];
		return (c[0] && u <= 4'h7) || (c[1] && u inside {4'h8, 4'h9})
			|| (c[2] && u inside {4'ha, 4'hb}) || (c[3] && u == 4'he && !bios);
	endfunction : exp_fwd
	// one-cycle strobes, changed just after the edge
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : reg_check
	task automatic defaults;
		reg_check(8'h45, 8'h10);
		reg_check(8'h46, 8'h0f);
		reg_check(8'h47, 8'h00);
		reg_check(8'h48, 8'h01);
	endtask : defaults
	// stream pci cycles, corners first, result checked two edges later
	task automatic pci_run(input logic [7:0] b, t, m, input logic en);
		logic [1:0] p1, p2;
		logic [31:0] a;
		logic r;
		logic [7:0] n; // expected selects in this run
		logic lh; // hole flag of the last request
		p1 = 2'b10;
		p2 = 2'b10;
		n = 8'h00;
		lh = 1'b0;
		reg_write(8'h4a, 8'h00); // start the select count from zero
		master_en <= en;
		for (int i = 0; i < 60; i++) begin
			a = $urandom;
			if (i % 2 == 0) a[31:25] = 7'h00;
			r = i < 12 || $urandom_range(0, 3) != 0;
			case (i)
				0: a = {8'h00, b, 16'h0000};
				1: a = {8'h00, t, 16'hffff};
				2: a = {8'h00, b - 8'h01, 16'hffff};
				3: a = {8'h00, t + 8'h01, 16'h0000};
				4: a = {3'h0, m, 21'h1fffff};
				5: a = {3'h0, m + 8'h01, 21'h000000};
				6: a = 32'h001fffff;
				7: a = 32'h00200000;
				8: a = {8'h01, b, 16'h0000};
				9: a = 32'h1fffffff;
				10: a = 32'h20000000;
				default: ;
			endcase
			@(posedge mclk);
			req <= r;
			req_addr <= a;
			#1 if (i >= 2) check({6'h00, sel_n, pci_done}, {6'h00, p2});
			p2 = p1;
			p1 = {~(r && exp_sel(a, b, t, m, en)), r};
			n += {7'h00, ~p1[1]};
			if (r) lh = exp_hole(a, b, t);
		end
		@(posedge mclk);
		req <= 1'b0;
		repeat (2) @(posedge mclk);
		reg_check(8'h4a, n);
		reg_check(8'h49, {2'b00, lh, 2'b00, en, m != 8'h00, t >= b});
	endtask : pci_run
	// stream isa cycles, every 64k unit below 1 mbyte and the top edges
	task automatic isa_run(input logic [7:0] c, input logic bios);
		logic [1:0] p1;
		logic [23:0] a;
		logic r;
		logic [7:0] n; // expected forwards in this run
		p1 = 2'b00;
		n = 8'h00;
		reg_write(8'h4b, 8'h00); // start the forward count from zero
		bios_en <= bios;
		for (int i = 0; i < 60; i++) begin
			a = 24'($urandom);
			r = i < 20 || $urandom_range(0, 3) != 0;
			if (i < 16) a = {4'h0, i[3:0], 16'h0000};
			if (i == 16) a = {c[7:4], 20'hfffff};
			if (i == 17) a = {c[7:4] + 4'h1, 20'h00000};
			if (i == 18) a = 24'h0fffff;
			@(posedge mclk);
			isa_valid <= r;
			isa_addr <= a;
			#1 if (i >= 1) check({6'h00, fwd, isa_done}, {6'h00, p1});
			p1 = {r && exp_fwd(a, c, bios), r};
			n += {7'h00, p1[1]};
		end
		@(posedge mclk);
		isa_valid <= 1'b0;
		reg_check(8'h4b, n);
	endtask : isa_run
	initial begin
		void'($urandom(32'hbc43e5ce));
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		defaults();
		reg_check(8'h50, 8'h00);
		reg_write(8'h50, 8'hff);
		reg_check(8'h45, 8'h10);
		// software keeps the hole bottom at or above 1 mbyte in every setting
		pci_run(8'h10, 8'h0f, 8'h00, 1'b1);
		reg_write(8'h47, 8'h10);
		reg_check(8'h47, 8'h10);
		pci_run(8'h10, 8'h0f, 8'h10, 1'b1);
		reg_write(8'h45, 8'h30);
		reg_write(8'h46, 8'h3f);
		reg_check(8'h45, 8'h30);
		reg_check(8'h46, 8'h3f);
		pci_run(8'h30, 8'h3f, 8'h10, 1'b1);
		pci_run(8'h30, 8'h3f, 8'h10, 1'b0);
		reg_write(8'h47, 8'hff);
		reg_write(8'h46, 8'h2f);
		pci_run(8'h30, 8'h2f, 8'hff, 1'b1);
		reg_write(8'h47, 8'h00);
		reg_write(8'h45, 8'h12);
		reg_write(8'h46, 8'hfe);
		pci_run(8'h12, 8'hfe, 8'h00, 1'b1);
		for (int k = 0; k < 5; k++) begin
			logic [7:0] c;
			c = (k == 4) ? 8'h01 : 8'h00;
			if (k < 4) c = {4'($urandom_range(0, 15)), 4'hf};
			if (k == 3) c = 8'hf5;
			reg_write(8'h48, c);
			reg_check(8'h48, c);
			isa_run(c, 1'b0);
			isa_run(c, 1'b1);
		end
		// second reset mid-run restores the defaults; move them away first
		reg_write(8'h47, 8'h3c);
		reg_write(8'h48, 8'h5a);
		@(posedge mclk);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		defaults();
		finish_test();
	end
	// watchdog well beyond the expected run
	initial begin
		#(25 * 20000);
		miscompares++;
		finish_test();
	end
endmodule : main_memory_select_decode_tb
`default_nettype wire
